//--- ddrt_top.sv
// Dual direction registered transceiver, two 8-bit halves
`timescale 1ns/1ps
`include "ddrt_regs.svh"

module ddrt_top
   import ddrt_pkg::*;
(
   input wire logic clk_in,
   input wire logic rst_b_in,
   input wire ddrt_dir_ctrl_t fwd_ctrl_in,
   input wire ddrt_dir_ctrl_t rev_ctrl_in,
   input wire logic [`DDRT_PORT_W-1:0] a_port_in,
   output logic [`DDRT_PORT_W-1:0] a_port_out,
   output logic [`DDRT_PORT_W-1:0] a_port_oe_b_out,
   input wire logic [`DDRT_PORT_W-1:0] b_port_in,
   output logic [`DDRT_PORT_W-1:0] b_port_out,
   output logic [`DDRT_PORT_W-1:0] b_port_oe_b_out
);

   // Spread one enable bit per half over that half's eight lanes
   function automatic logic [`DDRT_PORT_W-1:0] ddrt_spread(input logic [1:0] v);
      ddrt_spread = {{`DDRT_HALF_W{v[1]}}, {`DDRT_HALF_W{v[0]}}};
   endfunction : ddrt_spread

   // Synchronised control pins; controls and data share the same delay
   ddrt_dir_ctrl_t fwd_s;  // Forward controls after two stages
   ddrt_dir_ctrl_t rev_s;  // Reverse controls after two stages
   logic [`DDRT_PORT_W-1:0] a_sync;  // Port A data after two stages
   logic [`DDRT_PORT_W-1:0] b_sync;  // Port B data after two stages

   // Previous synchronised capture clocks for edge detection
   logic [1:0] fwd_clk_q;
   logic [1:0] rev_clk_q;

   // Edges counted since reset release
   logic [1:0] arm_cnt;
   wire armed;  // Pin history is real, loads and drives allowed

   // Undriven value for a whole port
   wire [`DDRT_PORT_W-1:0] oe_all_off;

   // Per half load strobes
   wire [1:0] fwd_edge;
   wire [1:0] rev_edge;
   wire [1:0] fwd_load;
   wire [1:0] rev_load;

   // Data registers of both directions
   logic [`DDRT_PORT_W-1:0] fwd_data;  // Drives port B
   logic [`DDRT_PORT_W-1:0] rev_data;  // Drives port A

   // Next values of the output enables
   wire [`DDRT_PORT_W-1:0] next_b_oe_b;
   wire [`DDRT_PORT_W-1:0] next_a_oe_b;

   // Controls pass two flip-flops; the far side keeps them defined
   ddrt_sync #(.W($bits(ddrt_dir_ctrl_t))) u_fwd_sync (
      .clk_in(clk_in),
      .rst_b_in(rst_b_in),
      .async_in(fwd_ctrl_in),
      .sync_out(fwd_s)
   );

   // Reverse controls, same delay as the forward ones
   ddrt_sync #(.W($bits(ddrt_dir_ctrl_t))) u_rev_sync (
      .clk_in(clk_in),
      .rst_b_in(rst_b_in),
      .async_in(rev_ctrl_in),
      .sync_out(rev_s)
   );

   // Port A data, aligned with the control path
   ddrt_sync #(.W(`DDRT_PORT_W)) u_a_sync (
      .clk_in(clk_in),
      .rst_b_in(rst_b_in),
      .async_in(a_port_in),
      .sync_out(a_sync)
   );

   // Port B data, aligned with the control path
   ddrt_sync #(.W(`DDRT_PORT_W)) u_b_sync (
      .clk_in(clk_in),
      .rst_b_in(rst_b_in),
      .async_in(b_port_in),
      .sync_out(b_sync)
   );

   // Edge history; cleared on reset, trusted only once armed
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         fwd_clk_q <= '0;
         rev_clk_q <= '0;
      end else begin
         fwd_clk_q <= fwd_s.capture_clock;
         rev_clk_q <= rev_s.capture_clock;
      end
   end

   // Synchronisers show cleared levels for a while after reset, so a clock
   // pin already high at release would look like a fresh edge without this
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         arm_cnt <= '0;
      end else if (!armed) begin
         arm_cnt <= arm_cnt + 2'h1;
      end
   end

   // Armed once edge history and enables both hold real pin levels
   assign armed = (arm_cnt == 2'(`DDRT_ARM_EDGES));
   assign oe_all_off = {`DDRT_PORT_W{`DDRT_OE_OFF}};

   // Rising edges of each half's capture clock
   assign fwd_edge = fwd_s.capture_clock & ~fwd_clk_q;
   assign rev_edge = rev_s.capture_clock & ~rev_clk_q;

   // Load only when the active-low capture enable is low
   assign fwd_load = fwd_edge & ~fwd_s.capture_enable_n & {2{armed}};
   assign rev_load = rev_edge & ~rev_s.capture_enable_n & {2{armed}};

   // Output enables follow the synchronised pins, per half
   // Cleared enable stages read as drive, so ports stay off until armed
   assign next_b_oe_b = armed ? ddrt_spread(fwd_s.output_enable_n) : oe_all_off;
   assign next_a_oe_b = armed ? ddrt_spread(rev_s.output_enable_n) : oe_all_off;

   // Each half loads on its own strobe, so halves never disturb each other
   // No reset here: contents are unknown until the first load
   always_ff @(posedge clk_in) begin
      for (int h = 0; h < `DDRT_HALVES; h++) begin
         if (fwd_load[h]) begin
            fwd_data[h*`DDRT_HALF_W +: `DDRT_HALF_W] <= a_sync[h*`DDRT_HALF_W +: `DDRT_HALF_W];
         end // Held otherwise
      end
   end

   // Reverse register, same form on its own controls
   always_ff @(posedge clk_in) begin
      for (int h = 0; h < `DDRT_HALVES; h++) begin
         if (rev_load[h]) begin
            rev_data[h*`DDRT_HALF_W +: `DDRT_HALF_W] <= b_sync[h*`DDRT_HALF_W +: `DDRT_HALF_W];
         end // Held otherwise
      end
   end

   // Enables reset to undriven, so ports float until told otherwise
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         b_port_oe_b_out <= {`DDRT_PORT_W{`DDRT_OE_OFF}};
         a_port_oe_b_out <= {`DDRT_PORT_W{`DDRT_OE_OFF}};
      end else begin
         b_port_oe_b_out <= next_b_oe_b;
         a_port_oe_b_out <= next_a_oe_b;
      end
   end

   // Port data comes straight from the data registers
   assign b_port_out = fwd_data;
   assign a_port_out = rev_data;

   // ---------------- Checks ----------------
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!rst_b_in);

   // Enabled rising edge of forward clock, low half
   sequence fwd_cap0_s;
      !fwd_s.capture_clock[0] ##1 (fwd_s.capture_clock[0] && !fwd_s.capture_enable_n[0] && armed);
   endsequence

   // Enabled rising edge of forward clock, high half
   sequence fwd_cap1_s;
      !fwd_s.capture_clock[1] ##1 (fwd_s.capture_clock[1] && !fwd_s.capture_enable_n[1] && armed);
   endsequence

   // Enabled rising edge of reverse clock, high half
   sequence rev_cap1_s;
      !rev_s.capture_clock[1] ##1 (rev_s.capture_clock[1] && !rev_s.capture_enable_n[1] && armed);
   endsequence

   // Load takes the sampled source value one cycle later
   fwd_load_low_a: assert property (
      fwd_cap0_s |=> b_port_out[7:0] == $past(a_sync[7:0]))
      else $error("forward low half did not load port A");

   // Reverse high half loads port B value
   rev_load_high_a: assert property (
      rev_cap1_s |=> a_port_out[15:8] == $past(b_sync[15:8]))
      else $error("reverse high half did not load port B");

   // Disabled edge leaves forward data unchanged
   fwd_hold_en_a: assert property (
      (fwd_edge[1] && fwd_s.capture_enable_n[1]) |=> $stable(b_port_out[15:8]))
      else $error("forward high half changed while capture disabled");

   // No edge means reverse data stays put
   rev_hold_noedge_a: assert property (
      !rev_edge[0] |=> $stable(a_port_out[7:0]))
      else $error("reverse low half changed without an edge");

   // Forward enable reaches port B three cycles after the pin
   fwd_oe_follow_a: assert property (
      $rose(fwd_ctrl_in.output_enable_n[0]) |-> ##3 (b_port_oe_b_out[7:0] == 8'hff))
      else $error("port B low half not released after enable went high");

   // Reverse enable low drives port A high half
   rev_oe_drive_a: assert property (
      $fell(rev_s.output_enable_n[1]) && armed |=> (a_port_oe_b_out[15:8] == 8'h00)[*2]
      or (a_port_oe_b_out[15:8] == 8'h00 ##1 $past(rev_s.output_enable_n[1])))
      else $error("port A high half not driven after enable went low");

   // A forward load on the low half never touches the high half
   half_isolate_a: assert property (
      (fwd_load[0] && !fwd_load[1]) |=> $stable(b_port_out[15:8]))
      else $error("forward high half changed on a low half load");

   // Both halves loaded together act as one 16-bit word
   word_join_a: assert property (
      (rev_load == 2'b11) |=> a_port_out == $past(b_sync))
      else $error("joined reverse word mismatch");

   // Forward high half loads port A value
   fwd_load_high_a: assert property (
      fwd_cap1_s |=> b_port_out[15:8] == $past(a_sync[15:8]))
      else $error("forward high half did not load port A");

   // Disabled edge leaves reverse data unchanged
   rev_hold_en_a: assert property (
      (rev_edge[1] && rev_s.capture_enable_n[1]) |=> $stable(a_port_out[15:8]))
      else $error("reverse high half changed while capture disabled");

   // Ports stay undriven until pin levels are settled after reset
   oe_arm_off_a: assert property (
      !armed |=> (a_port_oe_b_out == 16'hffff && b_port_oe_b_out == 16'hffff))
      else $error("port driven before pin levels were settled");

   // Reverse enable reaches port A three cycles after the pin
   rev_oe_follow_a: assert property (
      $rose(rev_ctrl_in.output_enable_n[0]) |-> ##3 (a_port_oe_b_out[7:0] == 8'hff))
      else $error("port A low half not released after enable went high");

   // A reverse load on the high half never touches the low half
   rev_half_isolate_a: assert property (
      (rev_load[1] && !rev_load[0]) |=> $stable(a_port_out[7:0]))
      else $error("reverse low half changed on a high half load");

endmodule : ddrt_top

//--- ddrt_regs.svh
// Constants for the dual direction registered transceiver
`ifndef DDRT_REGS_SVH
`define DDRT_REGS_SVH

// Width of one independent half of the data path
`define DDRT_HALF_W 8
// Number of independent halves
`define DDRT_HALVES 2
// Full data port width, both halves side by side
`define DDRT_PORT_W 16
// Flip-flop stages on every pin input
`define DDRT_SYNC_STAGES 2
// Output enable level that leaves a port undriven (active low enable)
`define DDRT_OE_OFF 1'b1
// Clock period in ns at 125 MHz
`define DDRT_CLK_PERIOD_NS 8
// Clock edges after reset before the pin history holds real levels
`define DDRT_ARM_EDGES 3

`endif

//--- ddrt_pkg.sv
// Types shared by the transceiver design files
package ddrt_pkg;

   // Control pins of one transfer direction, one bit per half
   typedef struct packed {
      logic [1:0] capture_clock;     // Rising edge loads the direction's register
      logic [1:0] capture_enable_n;  // Low allows a load on that edge
      logic [1:0] output_enable_n;   // Low drives the far port
   } ddrt_dir_ctrl_t;

endpackage : ddrt_pkg

//--- ddrt_sync.sv
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
`include "ddrt_regs.svh"

module ddrt_sync #(
   parameter int W = 1
) (
   input wire logic clk_in,
   input wire logic rst_b_in,
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] sync_out
);

   // First stage is read only by the second stage
   logic [W-1:0] meta;

   // Both stages clear on reset so no pin level leaks into reset state
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         meta <= '0;
         sync_out <= '0;
      end else begin
         meta <= async_in;
         sync_out <= meta;
      end
   end

endmodule : ddrt_sync

//--- ddrt_bus_model.sv
// Outside logic standing on one data port of the transceiver
`timescale 1ns/1ps
`include "ddrt_regs.svh"

module ddrt_bus_model (
   input wire logic [`DDRT_PORT_W-1:0] dev_data_in,  // Level the transceiver drives
   input wire logic [`DDRT_PORT_W-1:0] dev_oe_b_in,  // Low where the transceiver drives
   input wire logic [`DDRT_PORT_W-1:0] ext_data_in,  // Value the outside logic offers
   output logic [`DDRT_PORT_W-1:0] wire_out  // Resolved port level
);
   // Outside logic backs off where the device drives, so no contention
   assign wire_out = (dev_data_in & ~dev_oe_b_in) | (ext_data_in & dev_oe_b_in);
endmodule : ddrt_bus_model

//--- dual_direction_registered_transceiver_tb.sv
// Self-checking bench for the dual direction registered transceiver
`timescale 1ns/1ps
`include "ddrt_regs.svh"
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_fail++; \
   $display("[ERR] t=%0t got=%h exp=%h", $time, g, e); end end

module dual_direction_registered_transceiver_tb;
   import ddrt_pkg::*;
   logic clk_in;  // Bench clock
   logic rst_b_in;  // Active low reset
   ddrt_dir_ctrl_t fwd_ctrl;  // A to B controls
   ddrt_dir_ctrl_t rev_ctrl;  // B to A controls
   logic [15:0] a_ext, b_ext, a_wire, b_wire, a_out, a_oe_b, b_out, b_oe_b;
   int n_fail = 0;  // Mismatches
   int n_checks = 0;  // Comparisons
   int fwd_m[2];  // Model of forward registers
   int rev_m[2];  // Model of reverse registers
   bit fwd_k[2];  // Forward half loaded
   bit rev_k[2];  // Reverse half loaded

   ddrt_top dut_u (.clk_in(clk_in), .rst_b_in(rst_b_in), .fwd_ctrl_in(fwd_ctrl),
      .rev_ctrl_in(rev_ctrl), .a_port_in(a_wire), .a_port_out(a_out),
      .a_port_oe_b_out(a_oe_b), .b_port_in(b_wire), .b_port_out(b_out),
      .b_port_oe_b_out(b_oe_b));
   ddrt_bus_model a_bus_u (.dev_data_in(a_out), .dev_oe_b_in(a_oe_b),
      .ext_data_in(a_ext), .wire_out(a_wire));
   ddrt_bus_model b_bus_u (.dev_data_in(b_out), .dev_oe_b_in(b_oe_b),
      .ext_data_in(b_ext), .wire_out(b_wire));

   // Free running clock
   initial begin
      clk_in = 1'b0;
      forever #4 clk_in = ~clk_in;
   end

   task automatic cyc(input int n);
      repeat (n) @(posedge clk_in);
   endtask : cyc

   // Compare every half of both ports with the model
   task automatic compare_all;
      for (int h = 0; h < 2; h++) begin
         `CHK(b_oe_b[8*h+:8], {8{fwd_ctrl.output_enable_n[h]}})
         `CHK(a_oe_b[8*h+:8], {8{rev_ctrl.output_enable_n[h]}})
         // Unloaded halves hold no known value, so skipped
         if (fwd_k[h] && !fwd_ctrl.output_enable_n[h]) `CHK(b_wire[8*h+:8], fwd_m[h][7:0])
         if (rev_k[h] && !rev_ctrl.output_enable_n[h]) `CHK(a_wire[8*h+:8], rev_m[h][7:0])
      end
   endtask : compare_all

   // One capture in one direction; halves picked by mask
   task automatic op(input bit dir, input bit [1:0] mask);
      logic [1:0] en_n;
      en_n = 2'($urandom);
      a_ext <= 16'($urandom);
      b_ext <= 16'($urandom);
      fwd_ctrl.output_enable_n <= 2'($urandom);
      rev_ctrl.output_enable_n <= 2'($urandom);
      fwd_ctrl.capture_enable_n <= dir ? 2'b11 : en_n;
      rev_ctrl.capture_enable_n <= dir ? en_n : 2'b11;
      cyc(3);
      // Hold data three cycles before the rising edge
      if (dir) rev_ctrl.capture_clock <= mask;
      else fwd_ctrl.capture_clock <= mask;
      cyc(1);
      for (int h = 0; h < 2; h++) begin
         // Disabled halves keep old contents
         if (mask[h] && !en_n[h] && dir) begin
            rev_m[h] = fwd_ctrl.output_enable_n[h] ? b_ext[8*h+:8] : fwd_m[h];
            rev_k[h] = fwd_ctrl.output_enable_n[h] | fwd_k[h];
         end else if (mask[h] && !en_n[h]) begin
            fwd_m[h] = rev_ctrl.output_enable_n[h] ? a_ext[8*h+:8] : rev_m[h];
            fwd_k[h] = rev_ctrl.output_enable_n[h] | rev_k[h];
         end
      end
      cyc(2);
      fwd_ctrl.capture_clock <= 2'b00;
      rev_ctrl.capture_clock <= 2'b00;
      cyc(5);
      compare_all();
   endtask : op

   // Load every half both ways with ports undriven, so no unknown word
   // ever loops from one register into the other
   task automatic prime;
      a_ext <= 16'($urandom);
      b_ext <= 16'($urandom);
      fwd_ctrl <= '{2'b00, 2'b00, 2'b11};
      rev_ctrl <= '{2'b00, 2'b00, 2'b11};
      cyc(3);
      fwd_ctrl.capture_clock <= 2'b11;
      rev_ctrl.capture_clock <= 2'b11;
      cyc(3);
      fwd_ctrl <= '{2'b00, 2'b00, 2'b00};
      rev_ctrl <= '{2'b00, 2'b00, 2'b00};
      for (int h = 0; h < 2; h++) begin
         fwd_m[h] = a_ext[8*h+:8];
         rev_m[h] = b_ext[8*h+:8];
         fwd_k[h] = 1'b1;
         rev_k[h] = 1'b1;
      end
      cyc(5);
      compare_all();
   endtask : prime

   // Reset mid-run: ports released, data kept
   task automatic mid_reset;
      rst_b_in <= 1'b0;
      cyc(2);
      `CHK({a_oe_b, b_oe_b}, {32{`DDRT_OE_OFF}})
      rst_b_in <= 1'b1;
      fwd_ctrl.output_enable_n <= 2'b00;
      rev_ctrl.output_enable_n <= 2'b00;
      cyc(6);
      compare_all();
   endtask : mid_reset

   task automatic end_sim;
      $display("checks=%0d fails=%0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : end_sim

   // Main sequence; controls never left undefined
   initial begin
      void'($urandom(37));
      rst_b_in = 1'b0;
      fwd_ctrl = '{2'b00, 2'b11, 2'b11};
      rev_ctrl = '{2'b00, 2'b11, 2'b11};
      a_ext = 16'h0000;
      b_ext = 16'h0000;
      cyc(4);
      rst_b_in <= 1'b1;
      cyc(2);
      prime();
      for (int i = 0; i < 60; i++) begin
         op(1'($urandom), 2'($urandom_range(1, 3)));
         if (i == 30) mid_reset();
      end
      end_sim();
   end

   // Watchdog, well past the expected run
   initial begin
      #100000;
      n_fail++;
      end_sim();
   end
endmodule : dual_direction_registered_transceiver_tb
